// [i2c_spike_pkg.sv]
`default_nettype none
package i2c_spike_pkg;
    // bus shape
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_ENABLE_STATUS = 8'h9c;
    localparam logic [ADDR_W-1:0] OFF_SPIKE_LEN     = 8'ha0;
    localparam logic [ADDR_W-1:0] OFF_RESTART_CLR   = 8'ha8;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS    = 8'hb0;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR     = 8'hb4;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE    = 8'hb8;
    localparam logic [ADDR_W-1:0] OFF_COMP_PARAMS   = 8'hf4;
    localparam logic [ADDR_W-1:0] OFF_COMP_VERSION  = 8'hf8;
    localparam logic [ADDR_W-1:0] OFF_COMP_TYPE     = 8'hfc;
    // spike length field
    localparam int unsigned SPIKE_LEN_W = 8;
    localparam logic [SPIKE_LEN_W-1:0] SPIKE_LEN_RESET = 8'h07;
    localparam logic [SPIKE_LEN_W-1:0] SPIKE_LEN_MIN   = 8'h01;
    // field positions
    localparam int unsigned ENABLE_STATUS_BIT = 0;
    localparam int unsigned RESTART_CLR_BIT   = 0;
    localparam int unsigned RAW_RESTART_BIT   = 12;
    localparam int unsigned SPIKE_STRB_LANE   = 0;
    // interrupt sources
    localparam int unsigned IRQ_NUM       = 3;
    localparam int unsigned IRQ_RESTART   = 0;
    localparam int unsigned IRQ_SCL_SPIKE = 1;
    localparam int unsigned IRQ_SDA_SPIKE = 2;
    // constant contents
    localparam logic [DATA_W-1:0] COMP_PARAMS_VALUE = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_ZERO         = 32'h0000_0000;
    localparam logic              PIN_IDLE          = 1'b1;
endpackage
`default_nettype wire

// [sticky_irq.sv]
`default_nettype none
module sticky_irq #(
    parameter int unsigned N = 3
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [N-1:0] event_pulse,
    input  wire logic [N-1:0] clear_mask,
    input  wire logic [N-1:0] enable_mask,
    output logic      [N-1:0] status,
    output logic              irq
);
    typedef struct packed {
        logic [N-1:0] status;
    } irq_state_t;

    irq_state_t st_reg;
    irq_state_t st_next;

    // sticky bits, a new event beats a clear in the same cycle
    always_comb begin
        st_next        = st_reg;
        st_next.status = (st_reg.status & ~clear_mask) | event_pulse;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign status = st_reg.status;
    assign irq    = |(st_reg.status & enable_mask); // level, from flops

    a_irq_set_wins: assert property (@(posedge clk) disable iff (!nrst)
        |event_pulse |=> |(status & $past(event_pulse)))
        else $error("irq event lost against clear");
endmodule
`default_nettype wire

// [spike_glitch_filter.sv]
`default_nettype none
module spike_glitch_filter #(
    parameter int unsigned LEN_W = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             pin_in,
    input  wire logic [LEN_W-1:0] limit,
    output logic                  level,
    output logic                  spike
);
    import i2c_spike_pkg::*;

    typedef struct packed {
        logic             sync1;
        logic             sync2;
        logic             level;
        logic [LEN_W-1:0] cnt;
        logic             spike;
    } filt_state_t;

    filt_state_t st_reg;
    filt_state_t st_next;

    // two-flop sync, then count cycles the new level has held
    always_comb begin
        st_next       = st_reg;
        st_next.sync1 = pin_in;
        st_next.sync2 = st_reg.sync1;
        st_next.spike = 1'b0;
        if (st_reg.sync2 == st_reg.level) begin
            st_next.cnt   = '0;
            st_next.spike = (st_reg.cnt != '0); // short pulse discarded [R10]
        end else if (st_reg.cnt >= limit) begin
            st_next.level = st_reg.sync2; // held longer than limit [R10]
            st_next.cnt   = '0;
        end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg       <= '0;
            st_reg.sync1 <= PIN_IDLE;
            st_reg.sync2 <= PIN_IDLE;
            st_reg.level <= PIN_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.level;
    assign spike = st_reg.spike;

    a_filter_hold_short: assert property (@(posedge clk) disable iff (!nrst) // [R10]
        (st_reg.sync2 != st_reg.level && st_reg.cnt < limit) |=> $stable(level))
        else $error("filter passed a pulse too short");
    a_filter_pass_long: assert property (@(posedge clk) disable iff (!nrst) // [R10]
        (st_reg.sync2 != st_reg.level && st_reg.cnt >= limit) |=> level == $past(st_reg.sync2))
        else $error("filter failed to pass a stable level");
endmodule
`default_nettype wire

// [i2c_spike_regs.sv]
`default_nettype none
// What this block does
// [R1] 8-bit spike length, resets to seven
// [R2] spike length writable only while disabled
// [R3] written value below one stores one
// [R4] software sets spike length before transfers
// [R5] reading restart clear drops flag, returns it
// [R6] component parameters read as zero
// [R7] constant 32-bit component version
// [R8] constant component type, two letters, number
// [R9] enable status mirrors internal enable output
// [R10] level passes only after exceeding spike length
// [R11] reserved bits read zero, ignore writes
module i2c_spike_regs #(
    // arbitrary identity values, not any real part
    parameter logic [31:0] COMP_VERSION_VALUE = 32'h0000_0100,
    parameter logic [31:0] COMP_TYPE_VALUE    = 32'h5158_0001
) (
    input  wire logic                              clk,
    input  wire logic                              nrst,
    input  wire logic [i2c_spike_pkg::ADDR_W-1:0]  paddr,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [i2c_spike_pkg::DATA_W-1:0]  pwdata,
    input  wire logic [i2c_spike_pkg::STRB_W-1:0]  pstrb,
    output logic      [i2c_spike_pkg::DATA_W-1:0]  prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    input  wire logic                              controller_enable,
    input  wire logic                              internal_enable_output,
    input  wire logic                              restart_event,
    input  wire logic                              scl_pin,
    input  wire logic                              sda_pin,
    output logic                                   scl_filtered,
    output logic                                   sda_filtered,
    output logic                                   restart_detected_flag,
    output logic      [i2c_spike_pkg::DATA_W-1:0]  raw_restart_status,
    output logic                                   irq
);
    import i2c_spike_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [SPIKE_LEN_W-1:0] spike_len;
        logic [DATA_W-1:0]      rdata;
        logic                   slverr;
        logic                   restart_flag;
        logic [IRQ_NUM-1:0]     irq_enable;
    } regs_state_t;

    regs_state_t st_reg;
    regs_state_t st_next;

    logic               setup_phase;
    logic               access_phase;
    logic               wr_done;
    logic               rd_done;
    logic               spike_wr;
    logic [IRQ_NUM-1:0] irq_events;
    logic [IRQ_NUM-1:0] irq_clear;
    logic [IRQ_NUM-1:0] irq_status;
    logic               scl_spike;
    logic               sda_spike;
    logic [DATA_W-1:0]  rd_word;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    // true for every offset this block answers
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (addr)
            OFF_ENABLE_STATUS,
            OFF_SPIKE_LEN,
            OFF_RESTART_CLR,
            OFF_IRQ_STATUS,
            OFF_IRQ_CLEAR,
            OFF_IRQ_ENABLE,
            OFF_COMP_PARAMS,
            OFF_COMP_VERSION,
            OFF_COMP_TYPE: hit = 1'b1;
            default:       hit = 1'b0;
        endcase
        return hit;
    endfunction

    // clamp a written length to the legal minimum
    function automatic logic [SPIKE_LEN_W-1:0] clamp_len(input logic [SPIKE_LEN_W-1:0] v);
        return (v < SPIKE_LEN_MIN) ? SPIKE_LEN_MIN : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb phases

    // zero wait states, data is captured in the setup cycle
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign pready       = access_phase;
    assign wr_done      = access_phase & pwrite;
    assign rd_done      = access_phase & ~pwrite;
    assign spike_wr     = wr_done & (paddr == OFF_SPIKE_LEN) & pstrb[SPIKE_STRB_LANE];

    ////////////////////////////////////////////////////////////////////////
    // read mux, reserved bits stay zero

    always_comb begin
        rd_word = READ_ZERO; // [R11]
        unique case (paddr)
            OFF_ENABLE_STATUS: rd_word[ENABLE_STATUS_BIT] = internal_enable_output; // [R9]
            OFF_SPIKE_LEN:     rd_word[SPIKE_LEN_W-1:0] = st_reg.spike_len;
            OFF_RESTART_CLR:   rd_word[RESTART_CLR_BIT] = st_reg.restart_flag; // [R5]
            OFF_IRQ_STATUS:    rd_word[IRQ_NUM-1:0] = irq_status;
            OFF_IRQ_ENABLE:    rd_word[IRQ_NUM-1:0] = st_reg.irq_enable;
            OFF_COMP_PARAMS:   rd_word = COMP_PARAMS_VALUE; // [R6]
            OFF_COMP_VERSION:  rd_word = COMP_VERSION_VALUE; // [R7]
            OFF_COMP_TYPE:     rd_word = COMP_TYPE_VALUE; // [R8]
            default:           rd_word = READ_ZERO;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next = st_reg;
        // capture answer at setup, held through access
        if (setup_phase) begin
            st_next.slverr = ~is_mapped(paddr);
            st_next.rdata  = pwrite ? READ_ZERO : rd_word;
        end
        // spike length, locked while enabled, clamped to one
        if (spike_wr && !controller_enable) begin // [R2]
            st_next.spike_len = clamp_len(pwdata[SPIKE_LEN_W-1:0]); // [R1] [R3]
        end
        // interrupt enable, low lane only
        if (wr_done && paddr == OFF_IRQ_ENABLE && pstrb[0]) begin
            st_next.irq_enable = pwdata[IRQ_NUM-1:0];
        end
        // restart flag: a read clears only the value it returned, new event wins
        if (rd_done && paddr == OFF_RESTART_CLR && st_reg.rdata[RESTART_CLR_BIT]) begin
            st_next.restart_flag = 1'b0; // [R5]
        end
        if (restart_event) begin
            st_next.restart_flag = 1'b1;
        end
    end

    // registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg           <= '0;
            st_reg.spike_len <= SPIKE_LEN_RESET; // [R1]
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata                = st_reg.rdata;
    assign pslverr               = access_phase & st_reg.slverr;
    assign restart_detected_flag = st_reg.restart_flag;

    // flag placed at its raw status position
    always_comb begin
        raw_restart_status                  = READ_ZERO;
        raw_restart_status[RAW_RESTART_BIT] = st_reg.restart_flag; // [R5]
    end

    ////////////////////////////////////////////////////////////////////////
    // spike filters on both lines

    spike_glitch_filter #(
        .LEN_W (SPIKE_LEN_W)
    ) u_scl_filter (
        .clk    (clk),
        .nrst   (nrst),
        .pin_in (scl_pin),
        .limit  (st_reg.spike_len),
        .level  (scl_filtered),
        .spike  (scl_spike)
    );

    spike_glitch_filter #(
        .LEN_W (SPIKE_LEN_W)
    ) u_sda_filter (
        .clk    (clk),
        .nrst   (nrst),
        .pin_in (sda_pin),
        .limit  (st_reg.spike_len),
        .level  (sda_filtered),
        .spike  (sda_spike)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupts

    // events feeding the sticky status
    always_comb begin
        irq_events                = '0;
        irq_events[IRQ_RESTART]   = restart_event;
        irq_events[IRQ_SCL_SPIKE] = scl_spike;
        irq_events[IRQ_SDA_SPIKE] = sda_spike;
    end

    // write-one-to-clear strobe
    always_comb begin
        irq_clear = '0;
        if (wr_done && paddr == OFF_IRQ_CLEAR && pstrb[0]) begin
            irq_clear = pwdata[IRQ_NUM-1:0];
        end
    end

    sticky_irq #(
        .N (IRQ_NUM)
    ) u_irq (
        .clk         (clk),
        .nrst        (nrst),
        .event_pulse (irq_events),
        .clear_mask  (irq_clear),
        .enable_mask (st_reg.irq_enable),
        .status      (irq_status),
        .irq         (irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_spike_reset_val: assert property (@(posedge clk) disable iff (!nrst) // [R1]
        $rose(nrst) |-> st_reg.spike_len == SPIKE_LEN_RESET)
        else $error("spike length not seven after reset");

    a_spike_write_lock: assert property (@(posedge clk) disable iff (!nrst) // [R2]
        (spike_wr && controller_enable) |=> $stable(st_reg.spike_len))
        else $error("spike length changed while enabled");

    a_spike_write_take: assert property (@(posedge clk) disable iff (!nrst) // [R2]
        (spike_wr && !controller_enable && pwdata[SPIKE_LEN_W-1:0] != '0)
        |=> st_reg.spike_len == $past(pwdata[SPIKE_LEN_W-1:0]))
        else $error("spike length write not applied");

    a_spike_clamp_one: assert property (@(posedge clk) disable iff (!nrst) // [R3]
        (spike_wr && !controller_enable && pwdata[SPIKE_LEN_W-1:0] == '0)
        |=> st_reg.spike_len == SPIKE_LEN_MIN)
        else $error("zero length not clamped to one");

    a_spike_never_zero: assert property (@(posedge clk) disable iff (!nrst) // [R3]
        st_reg.spike_len != '0)
        else $error("spike length held zero");

    a_restart_rd_clear: assert property (@(posedge clk) disable iff (!nrst) // [R5]
        (rd_done && paddr == OFF_RESTART_CLR && prdata[RESTART_CLR_BIT] && !restart_event)
        |=> !restart_detected_flag)
        else $error("restart flag survived clearing read");

    a_restart_rd_data: assert property (@(posedge clk) disable iff (!nrst) // [R5]
        (rd_done && paddr == OFF_RESTART_CLR)
        |-> prdata == {{(DATA_W-1){1'b0}}, $past(st_reg.restart_flag)})
        else $error("restart clear read returned wrong data");

    a_restart_set_wins: assert property (@(posedge clk) disable iff (!nrst)
        restart_event |=> restart_detected_flag)
        else $error("restart event lost");

    a_params_read_zero: assert property (@(posedge clk) disable iff (!nrst) // [R6]
        (rd_done && paddr == OFF_COMP_PARAMS) |-> prdata == READ_ZERO)
        else $error("component parameters not zero");

    a_version_read: assert property (@(posedge clk) disable iff (!nrst) // [R7]
        (rd_done && paddr == OFF_COMP_VERSION) |-> prdata == COMP_VERSION_VALUE)
        else $error("component version wrong");

    a_type_read: assert property (@(posedge clk) disable iff (!nrst) // [R8]
        (rd_done && paddr == OFF_COMP_TYPE) |-> prdata == COMP_TYPE_VALUE)
        else $error("component type wrong");

    a_enable_mirror: assert property (@(posedge clk) disable iff (!nrst) // [R9]
        (rd_done && paddr == OFF_ENABLE_STATUS)
        |-> prdata == {{(DATA_W-1){1'b0}}, $past(internal_enable_output)})
        else $error("enable status not mirrored");

    a_spike_reserved: assert property (@(posedge clk) disable iff (!nrst) // [R11]
        (rd_done && paddr == OFF_SPIKE_LEN) |-> prdata[DATA_W-1:SPIKE_LEN_W] == '0)
        else $error("reserved spike bits not zero");

    a_unmapped_error: assert property (@(posedge clk) disable iff (!nrst)
        (access_phase && $past(setup_phase) && !is_mapped(paddr)) |-> pslverr)
        else $error("unmapped access not flagged");

    // bus answer and register hold
    a_rdata_hold: assert property (@(posedge clk) disable iff (!nrst)
        !setup_phase |=> $stable(prdata))
        else $error("read data moved outside setup");

    a_mapped_no_error: assert property (@(posedge clk) disable iff (!nrst)
        (access_phase && $past(setup_phase) && is_mapped(paddr)) |-> !pslverr)
        else $error("mapped access flagged");

    a_write_reads_zero: assert property (@(posedge clk) disable iff (!nrst)
        wr_done |-> prdata == READ_ZERO)
        else $error("write answered with data");

    a_spike_only_write: assert property (@(posedge clk) disable iff (!nrst) // [R2]
        !spike_wr |=> $stable(st_reg.spike_len))
        else $error("spike length moved without write");

    a_spike_read_back: assert property (@(posedge clk) disable iff (!nrst) // [R1]
        (rd_done && paddr == OFF_SPIKE_LEN) |-> prdata[SPIKE_LEN_W-1:0] == $past(st_reg.spike_len))
        else $error("spike length read wrong");

    a_irq_enable_take: assert property (@(posedge clk) disable iff (!nrst)
        (wr_done && paddr == OFF_IRQ_ENABLE && pstrb[0])
        |=> st_reg.irq_enable == $past(pwdata[IRQ_NUM-1:0]))
        else $error("irq enable write lost");

    a_irq_clear_done: assert property (@(posedge clk) disable iff (!nrst)
        (irq_clear[IRQ_RESTART] && !restart_event) |=> !irq_status[IRQ_RESTART])
        else $error("restart irq not cleared");

    a_clear_reads_zero: assert property (@(posedge clk) disable iff (!nrst) // [R11]
        (rd_done && paddr == OFF_IRQ_CLEAR) |-> prdata == READ_ZERO)
        else $error("irq clear read not zero");

    a_status_reserved: assert property (@(posedge clk) disable iff (!nrst) // [R11]
        (rd_done && paddr == OFF_IRQ_STATUS) |-> prdata[DATA_W-1:IRQ_NUM] == '0)
        else $error("reserved status bits set");

    // restart flag corners
    a_restart_no_loss: assert property (@(posedge clk) disable iff (!nrst) // [R5]
        (rd_done && paddr == OFF_RESTART_CLR && !prdata[RESTART_CLR_BIT])
        |=> (!$past(restart_detected_flag) || restart_detected_flag))
        else $error("unreported restart flag cleared");
endmodule
`default_nettype wire

// [i2c_peer_model.sv]
`default_nettype none
// another device on the wires: pulls a line low for a set number of cycles
module i2c_peer_model (
    input  wire logic clk,
    output logic      scl_pin,
    output logic      sda_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic scl_low = 1'b0;
    logic sda_low = 1'b0;

    // released lines float to the pull-up level
    assign scl_pin = scl_low ? 1'b0 : 1'b1;
    assign sda_pin = sda_low ? 1'b0 : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // low pulse on line 0 (clock) or 1 (data), changed right after rising edges
    task automatic glitch(input int line, input int cycles);
        @(posedge clk);
        if (line == 0) scl_low <= 1'b1;
        else sda_low <= 1'b1;
        repeat (cycles) @(posedge clk);
        scl_low <= 1'b0;
        sda_low <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [test_i2c_spike_regs.sv]
`default_nettype none
module test_i2c_spike_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_spike_pkg::*;

    localparam logic [31:0] VERSION_VAL = 32'h0000_0203; // arbitrary identity value
    localparam logic [31:0] TYPE_VAL    = 32'h5158_0007; // arbitrary identity value

    typedef struct {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wd;
        logic [3:0]  strb;
        logic        en;
        logic        ie;
        logic [31:0] exp;
        logic        err;
    } row_t;

    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        en = 1'b0;
    logic        ie = 1'b0;
    logic        restart_event = 1'b0;
    logic        scl_pin;
    logic        sda_pin;
    logic        scl_filtered;
    logic        sda_filtered;
    logic        flag;
    logic [31:0] raw_status;
    logic        irq;
    int          bad_count = 0;
    int          compares = 0;
    logic [31:0] rd;
    logic        err;
    logic        low;

    // ordinary register accesses: read, write, expected data and error
    row_t rows [0:27] = '{
        '{1'b0, 8'ha0, 32'h0, 4'hf, 1'b0, 1'b0, 32'h7, 1'b0},
        '{1'b1, 8'ha0, 32'hffff_ff23, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'ha0, 32'h0, 4'hf, 1'b0, 1'b0, 32'h23, 1'b0},
        '{1'b1, 8'ha0, 32'h0, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'ha0, 32'h0, 4'hf, 1'b0, 1'b0, 32'h1, 1'b0},
        '{1'b1, 8'ha0, 32'h55, 4'hf, 1'b1, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'ha0, 32'h0, 4'hf, 1'b1, 1'b0, 32'h1, 1'b0},
        '{1'b1, 8'ha0, 32'h33, 4'he, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'ha0, 32'h0, 4'hf, 1'b0, 1'b0, 32'h1, 1'b0},
        '{1'b1, 8'ha0, 32'hff, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'ha0, 32'h0, 4'hf, 1'b0, 1'b0, 32'hff, 1'b0},
        '{1'b0, 8'hf4, 32'h0, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b1, 8'hf4, 32'hffff_ffff, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'hf4, 32'h0, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'hf8, 32'h0, 4'hf, 1'b0, 1'b0, VERSION_VAL, 1'b0},
        '{1'b1, 8'hf8, 32'h0, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'hf8, 32'h0, 4'hf, 1'b0, 1'b0, VERSION_VAL, 1'b0},
        '{1'b0, 8'hfc, 32'h0, 4'hf, 1'b0, 1'b0, TYPE_VAL, 1'b0},
        '{1'b0, 8'ha4, 32'h0, 4'hf, 1'b0, 1'b0, 32'h0, 1'b1},
        '{1'b1, 8'ha4, 32'h1, 4'hf, 1'b0, 1'b0, 32'h0, 1'b1},
        '{1'b0, 8'h9c, 32'h0, 4'hf, 1'b0, 1'b1, 32'h1, 1'b0},
        '{1'b0, 8'h9c, 32'h0, 4'hf, 1'b1, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'h9c, 32'h0, 4'hf, 1'b0, 1'b1, 32'h1, 1'b0},
        '{1'b0, 8'ha8, 32'h0, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'hb8, 32'h0, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'hb0, 32'h0, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b0, 8'hb4, 32'h0, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0},
        '{1'b1, 8'ha0, 32'h4, 4'hf, 1'b0, 1'b0, 32'h0, 1'b0} // length set before bus traffic
    };

    i2c_spike_regs #(
        .COMP_VERSION_VALUE(VERSION_VAL),
        .COMP_TYPE_VALUE   (TYPE_VAL)
    ) dut (
        .clk                   (clk),
        .nrst                  (nrst),
        .paddr                 (paddr),
        .psel                  (psel),
        .penable               (penable),
        .pwrite                (pwrite),
        .pwdata                (pwdata),
        .pstrb                 (pstrb),
        .prdata                (prdata),
        .pready                (pready),
        .pslverr               (pslverr),
        .controller_enable     (en),
        .internal_enable_output(ie),
        .restart_event         (restart_event),
        .scl_pin               (scl_pin),
        .sda_pin               (sda_pin),
        .scl_filtered          (scl_filtered),
        .sda_filtered          (sda_filtered),
        .restart_detected_flag (flag),
        .raw_restart_status    (raw_status),
        .irq                   (irq)
    );

    i2c_peer_model peer (
        .clk    (clk),
        .scl_pin(scl_pin),
        .sda_pin(sda_pin)
    );

    // 200 MHz core clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic complete_run;
        $display("counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16 && pready !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: no pready", $time);
            complete_run();
        end
    endtask

    // pulse one line and watch its filtered level for 20 cycles
    task automatic pulse_seen(input int l, input int c);
        low = 1'b0;
        fork
            peer.glitch(l, c);
            repeat (20) begin
                @(posedge clk);
                #1;
                if ((l == 0 ? scl_filtered : sda_filtered) === 1'b0) low = 1'b1;
            end
        join
    endtask

    task automatic pulse_restart;
        @(posedge clk);
        restart_event <= 1'b1;
        @(posedge clk);
        restart_event <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk);
            en <= rows[i].en;
            ie <= rows[i].ie;
            apb(rows[i].wr, rows[i].addr, rows[i].wd, rows[i].strb);
            check({31'h0, err}, {31'h0, rows[i].err}, "error response");
            if (!rows[i].wr) check(rd, rows[i].exp, "read data");
        end
        $display("test register table done");
        // limit is now 4: a 4-cycle pulse is dropped, a 5-cycle level passes
        for (int l = 0; l < 2; l++) begin
            pulse_seen(l, 4);
            check({31'h0, low}, 32'h0, "short pulse passed");
            pulse_seen(l, 5);
            check({31'h0, low}, 32'h1, "long level blocked");
        end
        apb(1'b0, 8'hb0, 32'h0, 4'hf);
        check(rd, 32'h6, "spike events");
        apb(1'b1, 8'hb4, 32'h6, 4'hf);
        apb(1'b0, 8'hb0, 32'h0, 4'hf);
        check(rd, 32'h0, "spike events cleared");
        $display("test spike filter done");
        // restart flag, read-to-clear, interrupt raise, clear and mask
        apb(1'b1, 8'hb8, 32'h1, 4'hf);
        pulse_restart();
        check({31'h0, flag}, 32'h1, "flag not set");
        check(raw_status, 32'h0000_1000, "raw status");
        check({31'h0, irq}, 32'h1, "irq not raised");
        apb(1'b0, 8'ha8, 32'h0, 4'hf);
        check(rd, 32'h1, "clear read data");
        @(posedge clk);
        #1;
        check({31'h0, flag}, 32'h0, "flag not cleared");
        check(raw_status, 32'h0, "raw status kept");
        apb(1'b0, 8'ha8, 32'h0, 4'hf);
        check(rd, 32'h0, "second clear read");
        check({31'h0, irq}, 32'h1, "irq dropped by read");
        apb(1'b1, 8'hb4, 32'h1, 4'hf);
        #1;
        check({31'h0, irq}, 32'h0, "irq not cleared");
        apb(1'b1, 8'hb8, 32'h0, 4'hf);
        pulse_restart();
        check({31'h0, irq}, 32'h0, "masked irq raised");
        apb(1'b0, 8'hb0, 32'h0, 4'hf);
        check(rd, 32'h1, "masked status");
        $display("test restart and interrupt done");
        // reset in mid-run with the flag set
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        check({29'h0, flag, irq, scl_filtered}, 32'h1, "reset outputs");
        @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, 8'ha0, 32'h0, 4'hf);
        check(rd, 32'h7, "spike length after reset");
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
`default_nettype wire
